// ### hdl/page_frame_switch_decoder.sv
// Behaviour
// - answer at most eight consecutive pages from base
// - further pages count upward from base page
// - base switch up gives one; default zero
// - eight 32-byte flag blocks, enabled switch down
// - all flag switches up disables every block
// - count switches select one, two, four pages
// - delivered count setting gives one page
//
// Local design decisions: the address-and-strobe port and the address map.
module page_frame_switch_decoder (
   input wire logic clock,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [page_frame_pkg::SW_W-1:0] base_page_switches,
   input wire logic [page_frame_pkg::SW_W-1:0] flag_block_enable_switches,
   input wire logic [page_frame_pkg::SW_W-1:0] page_count_switches,
   input wire logic host_page_sel,
   input wire logic [page_frame_pkg::PAGE_W-1:0] host_page,
   input wire logic host_flag_sel,
   input wire logic [page_frame_pkg::FLAG_W-1:0] host_flag_addr,
   input wire logic [page_frame_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [page_frame_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic page_hit_q,
   output logic [page_frame_pkg::IDX_W-1:0] page_index_q,
   output logic page_if_q,
   output logic [page_frame_pkg::SLOT_W-1:0] page_slot_q,
   output logic flag_hit_q,
   output logic [page_frame_pkg::FLAG_BLK_W-1:0] flag_block_q,
   output logic [page_frame_pkg::FLAG_BLK_LSB-1:0] flag_byte_q,
   output logic [page_frame_pkg::DATA_W-1:0] reg_rdata_q
);
   import page_frame_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // pages in the window: per-interface pages times interface count
   function automatic logic [3:0] total_pages(input page_shift_t sh, input logic two);
      total_pages = 4'h1 << ({1'b0, sh} + {2'b00, two});
   endfunction

   // 32-byte flag block that a flag byte address falls in
   function automatic logic [FLAG_BLK_W-1:0] flag_block_of(input logic [FLAG_W-1:0] a);
      flag_block_of = a[FLAG_W-1:FLAG_BLK_LSB];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // switch sync and decode

   switch_cfg_if cfg ();

   switch_decoder u_dec (
      .clock(clock),
      .nrst(nrst),
      .ce(ce),
      .base_page_switches(base_page_switches),
      .flag_block_enable_switches(flag_block_enable_switches),
      .page_count_switches(page_count_switches),
      .cfg(cfg)
   );

   logic [1:0] ctrl_q, ctrl_d;
   logic [CNT_W-1:0] hits_q, hits_d;
   logic [DATA_W-1:0] rdata_d;
   logic [PAGE_W-1:0] page_off;
   logic [3:0] total;
   logic [SLOT_W-1:0] slot_mask;
   logic page_take;
   logic page_hit_d, page_if_d;
   logic [IDX_W-1:0] page_index_d, if_shifted;
   logic [SLOT_W-1:0] page_slot_d;
   logic [FLAG_BLK_W-1:0] flag_blk;
   logic flag_take;
   logic flag_hit_d;
   logic [FLAG_BLK_W-1:0] flag_block_d;
   logic [FLAG_BLK_LSB-1:0] flag_byte_d;
   logic [DATA_W-1:0] status;
   logic flag_chk;

   ////////////////////////////////////////////////////////////////////////////
   // page window decode

   // offset from base, bounded by the configured page count
   always_comb begin
      page_off = host_page - cfg.base_page;
      total = total_pages(cfg.page_shift, ctrl_q[CTRL_TWO_IF_BIT]);
      slot_mask = SLOT_W'(total_pages(cfg.page_shift, 1'b0) - 4'h1);
      page_take = host_page_sel && ctrl_q[CTRL_EN_BIT]
         && (host_page >= cfg.base_page) // no wrap below base
         && (page_off < {4'h0, total});
      if_shifted = page_off[IDX_W-1:0] >> cfg.page_shift;
      page_hit_d = page_take;
      page_index_d = page_take ? page_off[IDX_W-1:0] : 3'h0;
      page_if_d = page_take ? if_shifted[0] : 1'b0;
      page_slot_d = page_take ? (page_off[SLOT_W-1:0] & slot_mask) : 2'h0;
   end

   // page answer registers
   always_ff @(posedge clock) begin
      if (!nrst) begin
         page_hit_q <= 1'b0;
         page_index_q <= 3'h0;
         page_if_q <= 1'b0;
         page_slot_q <= 2'h0;
      end else if (ce) begin
         page_hit_q <= page_hit_d;
         page_index_q <= page_index_d;
         page_if_q <= page_if_d;
         page_slot_q <= page_slot_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // coordination flag decode

   // block index from the top address bits, gated by its enable
   always_comb begin
      flag_blk = flag_block_of(host_flag_addr);
      flag_take = host_flag_sel && ctrl_q[CTRL_EN_BIT]
         && cfg.flag_en[flag_blk];
      flag_hit_d = flag_take;
      flag_block_d = flag_take ? flag_blk : 3'h0;
      flag_byte_d = flag_take ? host_flag_addr[FLAG_BLK_LSB-1:0] : 5'h00;
   end

   // flag answer registers
   always_ff @(posedge clock) begin
      if (!nrst) begin
         flag_hit_q <= 1'b0;
         flag_block_q <= 3'h0;
         flag_byte_q <= 5'h00;
      end else if (ce) begin
         flag_hit_q <= flag_hit_d;
         flag_block_q <= flag_block_d;
         flag_byte_q <= flag_byte_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register port

   // control write, hit counter, read mux
   always_comb begin
      ctrl_d = ctrl_q;
      if (reg_wr && reg_addr == REG_CTRL) begin
         ctrl_d = reg_wdata[1:0];
      end
      // a hit in the clearing cycle still counts
      if (reg_wr && reg_addr == REG_HITS) begin
         hits_d = page_take ? 16'h0001 : HITS_RST;
      end else if (page_take && hits_q != HITS_MAX) begin
         hits_d = hits_q + 16'h0001;
      end else begin
         hits_d = hits_q;
      end
      status = '0;
      status[STAT_BASE_LSB +: PAGE_W] = cfg.base_page;
      status[STAT_SHIFT_LSB +: 2] = cfg.page_shift;
      status[STAT_FLAG_LSB +: FLAG_W] = cfg.flag_en;
      status[STAT_WARN_BIT] = cfg.unused_down;
      rdata_d = '0;
      if (reg_rd) begin
         case (reg_addr)
            REG_CTRL: rdata_d = {30'h00000000, ctrl_q};
            REG_STATUS: rdata_d = status;
            REG_HITS: rdata_d = {16'h0000, hits_q};
            default: rdata_d = '0; // unmapped reads zero
         endcase
      end
   end

   // register state
   always_ff @(posedge clock) begin
      if (!nrst) begin
         ctrl_q <= CTRL_RST;
         hits_q <= HITS_RST;
         reg_rdata_q <= '0;
      end else if (ce) begin
         ctrl_q <= ctrl_d;
         hits_q <= hits_d;
         reg_rdata_q <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   assign flag_chk = cfg.flag_en[host_flag_addr[7:5]];

   win_limit_a: assert property (
      ce && host_page_sel
      && {1'b0, host_page} >= {1'b0, cfg.base_page} + 9'h008 |=> !page_hit_q)
      else $error("page beyond eight from base was answered");

   count_up_a: assert property (
      ce && host_page_sel && ctrl_q[0] && host_page != 8'h00
      && host_page == cfg.base_page + 8'h01 && cfg.page_shift != SHIFT_ONE
      |=> page_hit_q && page_index_q == 3'h1 && page_slot_q == 2'h1)
      else $error("page after base not answered as index one");

   base_hit_a: assert property (
      ce && host_page_sel && ctrl_q[0] && host_page == cfg.base_page
      |=> page_hit_q && page_index_q == 3'h0 && !page_if_q)
      else $error("base page not answered as index zero");

   flag_gate_a: assert property (
      ce && host_flag_sel && ctrl_q[0] |=> flag_hit_q == $past(flag_chk))
      else $error("flag answer disagrees with block enable");

   flag_tile_a: assert property (
      flag_hit_q && $past(ce)
      |-> {flag_block_q, flag_byte_q} == $past(host_flag_addr))
      else $error("flag block and byte do not tile the address");

   read_slot_a: assert property (
      ce && !reg_rd |=> reg_rdata_q == 32'h00000000)
      else $error("read data present without a read");

   idle_page_a: assert property (
      ce && !host_page_sel
      |=> !page_hit_q && page_index_q == 3'h0 && !page_if_q && page_slot_q == 2'h0)
      else $error("idle page port left answer fields set");

   idle_flag_a: assert property (
      ce && !host_flag_sel
      |=> !flag_hit_q && flag_block_q == 3'h0 && flag_byte_q == 5'h00)
      else $error("idle flag port left answer fields set");

   flag_miss_a: assert property (
      ce && host_flag_sel && !flag_chk
      |=> !flag_hit_q && flag_block_q == 3'h0 && flag_byte_q == 5'h00)
      else $error("disabled flag block was answered");

   below_base_a: assert property (
      ce && host_page_sel && host_page < cfg.base_page |=> !page_hit_q)
      else $error("page below base was answered");

   off_refuse_a: assert property (
      ce && !ctrl_q[CTRL_EN_BIT] |=> !page_hit_q && !flag_hit_q)
      else $error("disabled decoder answered an access");

   one_if_a: assert property (
      ce && !ctrl_q[CTRL_TWO_IF_BIT] |=> !page_if_q)
      else $error("second interface used with one interface set");

   one_slot_a: assert property (
      ce && cfg.page_shift == SHIFT_ONE |=> page_slot_q == 2'h0)
      else $error("slot beyond zero with one page per interface");

   two_slot_a: assert property (
      ce && cfg.page_shift == SHIFT_TWO |=> !page_slot_q[1])
      else $error("slot beyond one with two pages per interface");

   flags_none_a: assert property (
      ce && cfg.flag_en == 8'h00 |=> !flag_hit_q)
      else $error("flag access answered with every block disabled");

   full_window_a: assert property (
      ce && host_page_sel && ctrl_q[CTRL_EN_BIT] && ctrl_q[CTRL_TWO_IF_BIT]
      && cfg.page_shift == SHIFT_FOUR
      && {1'b0, host_page} == {1'b0, cfg.base_page} + 9'h007
      |=> page_hit_q && page_index_q == 3'h7 && page_if_q && page_slot_q == 2'h3)
      else $error("eighth page of a full window not answered");

   status_read_a: assert property (
      ce && reg_rd && reg_addr == REG_STATUS
      |=> reg_rdata_q[STAT_WARN_BIT] == $past(cfg.unused_down))
      else $error("status read lost the unused switch warning");

   hits_clear_a: assert property (
      ce && reg_wr && reg_addr == REG_HITS && !page_take |=> hits_q == HITS_RST)
      else $error("hit counter not cleared by a write");

   hits_step_a: assert property (
      ce && !(reg_wr && reg_addr == REG_HITS) && page_take && hits_q != HITS_MAX
      |=> hits_q == $past(hits_q) + 16'h0001)
      else $error("hit counter did not step on a hit");

   hits_idle_a: assert property (
      ce && !(reg_wr && reg_addr == REG_HITS) && !page_take |=> $stable(hits_q))
      else $error("hit counter moved without a hit");

   ctrl_write_a: assert property (
      ce && reg_wr && reg_addr == REG_CTRL && reg_wdata[1:0] == 2'h1 |=> ctrl_q == 2'h1)
      else $error("control write did not land");

   frozen_a: assert property (
      !ce |=> $stable(page_hit_q) && $stable(flag_hit_q) && $stable(reg_rdata_q)
      && $stable(hits_q) && $stable(ctrl_q))
      else $error("state moved while the clock enable was low");

   cover_last_page: cover property (page_hit_q && page_index_q == 3'h7);
   cover_flag_hit: cover property (flag_hit_q && flag_block_q == 3'h7);
   cover_hit_clear: cover property (
      ce && reg_wr && reg_addr == REG_HITS && page_take ##1 hits_q == 16'h0001);
   cover_frozen: cover property (!ce ##1 ce);
   cover_one_if: cover property (ce && !ctrl_q[CTRL_TWO_IF_BIT] && page_take);

endmodule // page_frame_switch_decoder

// ### hdl/page_frame_pkg.sv
package page_frame_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // widths
   localparam int PAGE_W = 8;
   localparam int SW_W = 8;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int FLAG_W = 8;
   localparam int IDX_W = 3;
   localparam int SLOT_W = 2;
   localparam int CNT_W = 16;
   localparam int FLAG_BLK_LSB = 5;
   localparam int FLAG_BLK_W = 3;

   ////////////////////////////////////////////////////////////////////////////
   // register offsets and fields
   localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
   localparam logic [ADDR_W-1:0] REG_HITS = 4'h8;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_TWO_IF_BIT = 1;
   localparam logic [1:0] CTRL_RST = 2'h3;
   localparam int STAT_BASE_LSB = 0;
   localparam int STAT_SHIFT_LSB = 8;
   localparam int STAT_FLAG_LSB = 16;
   localparam int STAT_WARN_BIT = 24;
   localparam logic [CNT_W-1:0] HITS_RST = 16'h0000;
   localparam logic [CNT_W-1:0] HITS_MAX = 16'hFFFF;

   ////////////////////////////////////////////////////////////////////////////
   // switch positions and reset values
   localparam int CNT_POS0 = 0;
   localparam int CNT_POS1 = 1;
   localparam logic [3:0] MAX_PAGES = 4'h8;
   localparam logic [SW_W-1:0] BASE_SW_RST = 8'h00;
   localparam logic [SW_W-1:0] FLAG_SW_RST = 8'hFF;
   localparam logic [SW_W-1:0] CNT_SW_RST = 8'hFC;
   localparam logic [PAGE_W-1:0] BASE_RST = 8'h00;
   localparam logic [FLAG_W-1:0] FLAG_EN_RST = 8'h00;

   typedef enum logic [1:0] {
      SHIFT_ONE = 2'h0,
      SHIFT_TWO = 2'h1,
      SHIFT_FOUR = 2'h2
   } page_shift_t;

endpackage

// ### hdl/switch_cfg_if.sv
interface switch_cfg_if;
   import page_frame_pkg::*;
   logic [PAGE_W-1:0] base_page;
   page_shift_t page_shift;
   logic [FLAG_W-1:0] flag_en;
   logic unused_down;
   modport src (output base_page, output page_shift, output flag_en, output unused_down);
   modport dst (input base_page, input page_shift, input flag_en, input unused_down);
endinterface

// ### hdl/switch_decoder.sv
module switch_decoder (
   input wire logic clock,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [page_frame_pkg::SW_W-1:0] base_page_switches,
   input wire logic [page_frame_pkg::SW_W-1:0] flag_block_enable_switches,
   input wire logic [page_frame_pkg::SW_W-1:0] page_count_switches,
   switch_cfg_if.src cfg
);
   import page_frame_pkg::*;

   logic [SW_W-1:0] base_s1_q, base_s1_d, base_s2_q, base_s2_d;
   logic [SW_W-1:0] flag_s1_q, flag_s1_d, flag_s2_q, flag_s2_d;
   logic [SW_W-1:0] cnt_s1_q, cnt_s1_d, cnt_s2_q, cnt_s2_d;
   logic [PAGE_W-1:0] base_q, base_d;
   page_shift_t shift_q, shift_d;
   logic [FLAG_W-1:0] flag_en_q, flag_en_d;
   logic warn_q, warn_d;

   ////////////////////////////////////////////////////////////////////////////
   // two-stage pin sync, then decode of the settled switch levels
   always_comb begin
      base_s1_d = base_page_switches;
      flag_s1_d = flag_block_enable_switches;
      cnt_s1_d = page_count_switches;
      base_s2_d = base_s1_q;
      flag_s2_d = flag_s1_q;
      cnt_s2_d = cnt_s1_q;
      base_d = base_s2_q; // up reads as one
      flag_en_d = ~flag_s2_q; // down enables
      warn_d = ~&cnt_s2_q[SW_W-1:2]; // unused must stay up
      unique case ({cnt_s2_q[CNT_POS1], cnt_s2_q[CNT_POS0]})
         2'b00, 2'b01: shift_d = SHIFT_ONE;
         2'b10: shift_d = SHIFT_TWO;
         2'b11: shift_d = SHIFT_FOUR;
      endcase
   end

   // sync and decoded config registers
   always_ff @(posedge clock) begin
      if (!nrst) begin
         base_s1_q <= BASE_SW_RST;
         base_s2_q <= BASE_SW_RST;
         flag_s1_q <= FLAG_SW_RST;
         flag_s2_q <= FLAG_SW_RST;
         cnt_s1_q <= CNT_SW_RST;
         cnt_s2_q <= CNT_SW_RST;
         base_q <= BASE_RST;
         shift_q <= SHIFT_ONE;
         flag_en_q <= FLAG_EN_RST; // delivered: all blocks off
         warn_q <= 1'b0;
      end else if (ce) begin
         base_s1_q <= base_s1_d;
         base_s2_q <= base_s2_d;
         flag_s1_q <= flag_s1_d;
         flag_s2_q <= flag_s2_d;
         cnt_s1_q <= cnt_s1_d;
         cnt_s2_q <= cnt_s2_d;
         base_q <= base_d;
         shift_q <= shift_d;
         flag_en_q <= flag_en_d;
         warn_q <= warn_d;
      end
   end

   assign cfg.base_page = base_q;
   assign cfg.page_shift = shift_q;
   assign cfg.flag_en = flag_en_q;
   assign cfg.unused_down = warn_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks on the decode
   default clocking dcb @(posedge clock); endclocking
   default disable iff (!nrst);

   flags_off_a: assert property (
      ce && (&flag_s2_q) |=> flag_en_q == 8'h00)
      else $error("all flag switches up but a block is enabled");

   four_pages_a: assert property (
      ce && cnt_s2_q[1:0] == 2'b11 |=> shift_q == SHIFT_FOUR)
      else $error("both count switches up did not give four pages");

   one_page_a: assert property (
      ce && !cnt_s2_q[CNT_POS1] |=> shift_q == SHIFT_ONE)
      else $error("count position one down did not give one page");

endmodule // switch_decoder

// ### test/host_model.sv
// host controller side: issues page and flag accesses over the backplane
module host_model (
   input wire logic clock,
   output logic host_page_sel,
   output logic [page_frame_pkg::PAGE_W-1:0] host_page,
   output logic host_flag_sel,
   output logic [page_frame_pkg::FLAG_W-1:0] host_flag_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   import page_frame_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // idle bus at time zero
   initial begin
      host_page_sel = 1'b0;
      host_page = 8'h00;
      host_flag_sel = 1'b0;
      host_flag_addr = 8'h00;
   end

   // one-cycle page access; released address shows the inverse value
   task automatic page_access(input logic [PAGE_W-1:0] p);
      @(posedge clock);
      host_page_sel <= 1'b1;
      host_page <= p;
      @(posedge clock);
      host_page_sel <= 1'b0;
      host_page <= ~p;
   endtask

   // one-cycle flag access; released address shows the inverse value
   task automatic flag_access(input logic [FLAG_W-1:0] a);
      @(posedge clock);
      host_flag_sel <= 1'b1;
      host_flag_addr <= a;
      @(posedge clock);
      host_flag_sel <= 1'b0;
      host_flag_addr <= ~a;
   endtask
endmodule // host_model

// ### test/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import page_frame_pkg::*;

   logic clock, nrst, ce, reg_wr, reg_rd;
   logic [7:0] base_sw, flag_sw, cnt_sw;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata_q;
   logic host_page_sel, host_flag_sel, page_hit_q, page_if_q, flag_hit_q;
   logic [7:0] host_page, host_flag_addr;
   logic [2:0] page_index_q, flag_block_q;
   logic [1:0] page_slot_q;
   logic [4:0] flag_byte_q;
   int num_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   int hits = 0;
   logic [7:0] ppi, total, b;
   logic [1:0] sh;

   ////////////////////////////////////////////////////////////////////////////
   // clock, cycle ceiling
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors = num_errors + 1;
         test_done();
      end
   end

   page_frame_switch_decoder page_frame_switch_decoder_inst (.clock(clock), .nrst(nrst),
      .ce(ce), .base_page_switches(base_sw), .flag_block_enable_switches(flag_sw),
      .page_count_switches(cnt_sw), .host_page_sel(host_page_sel), .host_page(host_page),
      .host_flag_sel(host_flag_sel), .host_flag_addr(host_flag_addr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .page_hit_q(page_hit_q),
      .page_index_q(page_index_q), .page_if_q(page_if_q), .page_slot_q(page_slot_q),
      .flag_hit_q(flag_hit_q), .flag_block_q(flag_block_q), .flag_byte_q(flag_byte_q),
      .reg_rdata_q(reg_rdata_q));
   host_model host_model_inst (.clock(clock), .host_page_sel(host_page_sel),
      .host_page(host_page), .host_flag_sel(host_flag_sel), .host_flag_addr(host_flag_addr));

   ////////////////////////////////////////////////////////////////////////////
   // compare, report, bus tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared = n_compared + 1;
      if (seen !== exp) begin
         num_errors = num_errors + 1;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_chk(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 check(reg_rdata_q, exp);
   endtask
   task automatic page_chk(input logic [7:0] p, input logic h, input logic [7:0] idx,
                           input logic ifx, input logic [7:0] slot);
      host_model_inst.page_access(p);
      #1 check(page_hit_q, h);
      check(page_index_q, idx[2:0]);
      check(page_if_q, ifx);
      check(page_slot_q, slot[1:0]);
      if (h)
         hits = hits + 1;
   endtask
   task automatic flag_chk(input logic [7:0] a, input logic h, input logic [7:0] blk,
                           input logic [7:0] byt);
      host_model_inst.flag_access(a);
      #1 check(flag_hit_q, h);
      check(flag_block_q, blk[2:0]);
      check(flag_byte_q, byt[4:0]);
   endtask
   task automatic settle();
      repeat (6) @(posedge clock);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      nrst = 1'b0;
      ce = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0000_0000;
      base_sw = 8'h00;
      flag_sw = 8'hFF;
      cnt_sw = 8'hFC;
      repeat (4) @(posedge clock);
      nrst <= 1'b1;
      settle();
      reg_chk(REG_STATUS, 32'h0000_0000);
      @(posedge clock);
      #1 check(reg_rdata_q, 32'h0000_0000);
      reg_chk(REG_CTRL, 32'h0000_0003);
      reg_chk(REG_HITS, 32'h0000_0000);
      reg_chk(4'hC, 32'h0000_0000);
      page_chk(8'h00, 1'b1, 8'h00, 1'b0, 8'h00);
      page_chk(8'h01, 1'b1, 8'h01, 1'b1, 8'h00);
      page_chk(8'h02, 1'b0, 8'h00, 1'b0, 8'h00);
      flag_chk(8'h45, 1'b0, 8'h00, 8'h00);
      // every count switch code, base 0x10, two interfaces then one
      @(posedge clock);
      base_sw <= 8'h10;
      reg_write(REG_HITS, 32'h0000_0000);
      hits = 0;
      for (int c = 0; c < 4; c++) begin
         sh = c[1:0];
         cnt_sw <= {6'h3F, sh};
         ppi = (c < 2) ? 8'h01 : ((c == 2) ? 8'h02 : 8'h04);
         total = ppi << 1;
         settle();
         reg_chk(REG_STATUS, {22'h0, (c < 2) ? 2'h0 : sh - 2'h1, 8'h10});
         page_chk(8'h10 + ppi - 8'h01, 1'b1, ppi - 8'h01, 1'b0, ppi - 8'h01);
         page_chk(8'h10 + ppi, 1'b1, ppi, 1'b1, 8'h00);
         page_chk(8'h10 + total - 8'h01, 1'b1, total - 8'h01, 1'b1, ppi - 8'h01);
         page_chk(8'h10 + total, 1'b0, 8'h00, 1'b0, 8'h00);
         page_chk(8'h0F, 1'b0, 8'h00, 1'b0, 8'h00);
         reg_write(REG_CTRL, 32'h0000_0001);
         page_chk(8'h10 + ppi, 1'b0, 8'h00, 1'b0, 8'h00);
         reg_write(REG_CTRL, 32'h0000_0003);
      end
      reg_chk(REG_HITS, hits);
      // an unused count switch down is flagged, decode unchanged
      @(posedge clock);
      cnt_sw <= 8'h7F;
      settle();
      reg_chk(REG_STATUS, 32'h0100_0210);
      // window near the top of the page space does not wrap
      base_sw <= 8'hFC;
      settle();
      page_chk(8'hFF, 1'b1, 8'h03, 1'b0, 8'h03);
      page_chk(8'h00, 1'b0, 8'h00, 1'b0, 8'h00);
      // each flag block alone, ends of its byte range
      for (int n = 0; n < 8; n++) begin
         b = n[7:0];
         @(posedge clock);
         flag_sw <= ~(8'h01 << n);
         settle();
         flag_chk({b[2:0], 5'h1F}, 1'b1, b, 8'h1F);
         flag_chk({b[2:0], 5'h00}, 1'b1, b, 8'h00);
         flag_chk({b[2:0] + 3'h1, 5'h00}, 1'b0, 8'h00, 8'h00);
         reg_chk(REG_STATUS, {8'h01, 8'h01 << n, 16'h02FC});
      end
      // clock enable low freezes the decoder, an in-window access is lost
      @(posedge clock);
      ce <= 1'b0;
      page_chk(8'hFC, 1'b0, 8'h00, 1'b0, 8'h00);
      @(posedge clock);
      ce <= 1'b1;
      // disabled decoder refuses pages and flags
      reg_write(REG_CTRL, 32'h0000_0002);
      page_chk(8'hFC, 1'b0, 8'h00, 1'b0, 8'h00);
      flag_chk(8'hFF, 1'b0, 8'h00, 8'h00);
      // mid-run reset restores control and counter defaults
      @(posedge clock);
      nrst <= 1'b0;
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      reg_chk(REG_CTRL, 32'h0000_0003);
      reg_chk(REG_HITS, 32'h0000_0000);
      test_done();
   end
endmodule // tb
